// *** verilog/irq_prio_pkg.sv ***
// Constants shared by the priority map, its bus port and its selector.
// Assumes word-aligned AHB-Lite access, one register per 32-bit word.
package irq_prio_pkg;
	localparam int NUM_REGS = 8;
	localparam int NUM_MAP = 10;
	localparam int REG_W = 16;
	localparam int NUM_SRC = 12;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [15:0] REG_RESET = 16'h0000;
	// Byte offsets: eight priority words, then two read-only views
	localparam logic [31:0] MAP_OFS [NUM_MAP] = '{32'h00, 32'h04, 32'h08,
		32'h0C, 32'h10, 32'h14, 32'h18, 32'h1C, 32'h20, 32'h24};
	localparam logic [3:0] IDX_STATUS = 4'h8;
	localparam logic [3:0] IDX_PENDING = 4'h9;
	// Writable bits per priority word; low byte of the last is reserved
	localparam logic [15:0] REG_WMASK [NUM_REGS] = '{16'hFFFF, 16'hFFFF,
		16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFF00};
	// Source order is the fixed tie-break order, first wins
	localparam int S_ERR = 0;
	localparam int S_RX = 1;
	localparam int S_CONV1 = 5;
	localparam int S_WDOG = 9;
	localparam int S_BUS = 10;
	localparam int S_PORT = 11;
	localparam logic [7:0] SRC_VEC [NUM_SRC] = '{8'h84, 8'h85, 8'h86,
		8'h87, 8'h88, 8'h89, 8'h8C, 8'h90, 8'h94, 8'h98, 8'h99, 8'h9C};
	localparam int SRC_REG [NUM_SRC] = '{5, 5, 5, 5, 6, 6, 6, 6, 6, 7, 7, 7};
	localparam int SRC_FIELD [NUM_SRC] = '{3, 3, 3, 3, 0, 0, 1, 2, 3, 0, 0, 1};

	// Field 0 is bits 15:12, field 3 is bits 3:0
	function automatic logic [3:0] field_of(input logic [15:0] r,
		input int f);
		return r[(3 - f) * 4 +: 4];
	endfunction
endpackage

// *** verilog/reg_bus_if.sv ***
// Register access between the bus port and the register bank.
// Assumes both ends share mclk.
`timescale 1ns/10ps
interface reg_bus_if;
	logic wrEn;
	logic [3:0] idx;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport front (output wrEn, output idx, output wdata, input rdata);
	modport bank (input wrEn, input idx, input wdata, output rdata);
endinterface

// *** verilog/ahb_reg_port.sv ***
// AHB-Lite slave front end: decode, write strobe, one-wait read.
// Assumes a single master; response is always OKAY.
`timescale 1ns/10ps
module ahb_reg_port
	import irq_prio_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// AHB-Lite
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Register side
	reg_bus_if.front rb
);
	typedef struct packed {
		logic wrPh;
		logic rdWait;
		logic hit;
		logic [3:0] idx;
		logic [31:0] rdata;
	} port_st_t;
	port_st_t st, next_st;
	logic take;
	logic hitNow;
	logic [3:0] idxNow;

	////////////////////////////////////////////////////////////////////////
	// Address decode against the offset table
	always_comb begin
		hitNow = 1'b0;
		idxNow = 4'h0;
		for (int i = 0; i < NUM_MAP; i++) begin
			if (haddr == MAP_OFS[i] && hsize == HSIZE_WORD) begin
				hitNow = 1'b1;
				idxNow = 4'(i);
			end
		end
	end

	// Reads stall one cycle so a write just before is seen
	assign take = hsel && htrans[1] && hready;
	always_comb begin
		next_st = st;
		next_st.wrPh = 1'b0;
		next_st.rdWait = 1'b0;
		if (st.rdWait) begin
			next_st.rdata = st.hit ? {16'h0000, rb.rdata} : 32'h00000000;
		end
		if (take) begin
			next_st.wrPh = hwrite;
			next_st.rdWait = !hwrite;
			next_st.hit = hitNow;
			next_st.idx = idxNow;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Unmapped writes are dropped, unmapped reads give zero
	assign rb.wrEn = st.wrPh && st.hit;
	assign rb.idx = st.idx;
	assign rb.wdata = hwdata[15:0];
	assign hreadyout = !st.rdWait;
	assign hrdata = st.rdata;
	assign hresp = 1'b0;
endmodule

// *** verilog/prio_select.sv ***
// Picks the highest pending source and compares it with the CPU mask.
// Assumes requests and mask come from logic on mclk.
`timescale 1ns/10ps
module prio_select
	import irq_prio_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Sources and mask
	input wire logic [NUM_SRC-1:0] req,
	input wire logic [NUM_SRC-1:0][3:0] level,
	input wire logic [3:0] cpuMaskLevel,
	// To the CPU
	output logic irqReq,
	output logic [3:0] irqLevel,
	output logic [7:0] irqVector
);
	typedef struct packed {
		logic req;
		logic [3:0] lvl;
		logic [7:0] vec;
	} sel_st_t;
	sel_st_t st, next_st;
	logic found;
	logic [3:0] bestLvl;
	logic [7:0] bestVec;

	////////////////////////////////////////////////////////////////////////
	// Strict compare keeps the earlier source on equal levels
	always_comb begin
		found = 1'b0;
		bestLvl = 4'h0;
		bestVec = 8'h00;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (req[i] && (!found || level[i] > bestLvl)) begin // [RULE20]
				found = 1'b1;
				bestLvl = level[i];
				bestVec = SRC_VEC[i];
			end
		end
		next_st = '0;
		if (found && bestLvl > cpuMaskLevel) begin // [RULE19]
			next_st.req = 1'b1;
			next_st.lvl = bestLvl;
			next_st.vec = bestVec;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign irqReq = st.req;
	assign irqLevel = st.lvl;
	assign irqVector = st.vec;
endmodule

// *** verilog/interrupt_priority_map.sv ***
// Priority level register bank with source selection toward the CPU.
// Assumes requests, standby and mask are synchronous to mclk.
//
// Overview of operation
// RULE1 - Eight 16-bit read/write priority registers
// RULE2 - Four 4-bit fields per register
// RULE3 - Level 0 lowest, 15 highest, linear
// RULE4 - Power-on or manual reset clears all
// RULE5 - Standby leaves contents unchanged
// RULE6 - First register: external pins 0 to 3
// RULE7 - Second register: external pins 4 to 7
// RULE8 - Third register: DMA channels 0 to 3
// RULE9 - Fourth register: timer channels 0 and 1
// RULE10 - Fifth register: timer channels 2 and 3
// RULE11 - Sixth register: timer 4, serial 0, serial 1
// RULE12 - Seventh: converter, transfer, compare timers
// RULE13 - Eighth: watchdog/bus, port output, low reserved
// RULE14 - Shared field gives identical level
// RULE15 - Fixed vector numbers, table address times four
// RULE16 - Two converter sources share field, 136/137
// RULE17 - Each register serves four sources; here the seventh serves five and the eighth three
// RULE18 - Fixed ranking inside shared fields
// RULE19 - Forward only above CPU mask level
// RULE20 - Equal levels resolved by default order
//
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module interrupt_priority_map
	import irq_prio_pkg::*;
#(
	parameter bit TwoConverterSources = 1'b1
)
(
	// Clock and resets
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic manualRst_n,
	input wire logic standby,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Peripheral requests
	input wire logic serial1ErrorReq,
	input wire logic serial1RxReq,
	input wire logic serial1TxReq,
	input wire logic serial1TxEndReq,
	input wire logic converter0EndReq,
	input wire logic converter1EndReq,
	input wire logic xferSwRequest,
	input wire logic cmpTimer0MatchReq,
	input wire logic cmpTimer1MatchReq,
	input wire logic wdogIntervalReq,
	input wire logic busRefreshMatchReq,
	input wire logic portOutputReq,
	// CPU side
	input wire logic [3:0] cpuMaskLevel,
	output logic irqReq,
	output logic [3:0] irqLevel,
	output logic [7:0] irqVector,
	output logic [9:0] irqVecAddr,
	// Levels for sources selected elsewhere
	output logic [31:0] extPinLevels,
	output logic [15:0] dmaLevels,
	output logic [39:0] timerLevels,
	output logic [3:0] serial0Level
);
	typedef struct packed {
		logic [NUM_REGS-1:0][REG_W-1:0] prio;
		logic [NUM_SRC-1:0] pendSeen;
	} map_st_t;
	map_st_t st, next_st;
	logic [NUM_SRC-1:0] reqs;
	logic [NUM_SRC-1:0][3:0] srcLevel;
	logic [15:0] statusWord;
	reg_bus_if rb ();

	////////////////////////////////////////////////////////////////////////
	// Bus front end
	ahb_reg_port u_port (
		.mclk(mclk),
		.rst_n(rst_n),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hrdata(hrdata),
		.hresp(hresp),
		.rb(rb)
	);

	////////////////////////////////////////////////////////////////////////
	// Request vector in tie-break order; second converter optional
	assign reqs = {portOutputReq, busRefreshMatchReq, wdogIntervalReq,
		cmpTimer1MatchReq, cmpTimer0MatchReq, xferSwRequest,
		converter1EndReq && TwoConverterSources, converter0EndReq,
		serial1TxEndReq, serial1TxReq, serial1RxReq,
		serial1ErrorReq}; // [RULE16] [RULE18]

	// Each source reads its own field; shared fields fan out
	for (genvar i = 0; i < NUM_SRC; i++) begin : g_lvl
		assign srcLevel[i] = field_of(st.prio[SRC_REG[i]],
			SRC_FIELD[i]); // [RULE2] [RULE12] [RULE14] [RULE17]
	end

	////////////////////////////////////////////////////////////////////////
	// Register bank update; standby has no path in here at all
	always_comb begin
		next_st = st;
		next_st.pendSeen = reqs;
		if (rb.wrEn && rb.idx < 4'(NUM_REGS)) begin
			next_st.prio[rb.idx[2:0]] =
				rb.wdata & REG_WMASK[rb.idx[2:0]]; // [RULE1] [RULE13]
		end
		if (!manualRst_n) begin
			next_st.prio = '0; // [RULE4]
		end
	end

	// Synchronous reset clears; standby only stops the clock outside
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st <= '0; // [RULE4] [RULE5]
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux, including the two status views
	assign statusWord = {irqReq, 3'h0, irqLevel, irqVector};
	always_comb begin
		if (rb.idx == IDX_STATUS) begin
			rb.rdata = statusWord;
		end else if (rb.idx == IDX_PENDING) begin
			rb.rdata = {4'h0, st.pendSeen};
		end else if (rb.idx < 4'(NUM_REGS)) begin
			rb.rdata = st.prio[rb.idx[2:0]]; // [RULE1]
		end else begin
			rb.rdata = 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Selection toward the CPU; one cycle of latency
	prio_select u_sel (
		.mclk(mclk),
		.rst_n(rst_n && manualRst_n),
		.req(reqs),
		.level(srcLevel),
		.cpuMaskLevel(cpuMaskLevel),
		.irqReq(irqReq),
		.irqLevel(irqLevel), // [RULE3]
		.irqVector(irqVector)
	);
	assign irqVecAddr = {irqVector, 2'b00}; // [RULE15]

	////////////////////////////////////////////////////////////////////////
	// Register contents for sources arbitrated elsewhere
	assign extPinLevels = {st.prio[0], st.prio[1]}; // [RULE6] [RULE7]
	assign dmaLevels = st.prio[2]; // [RULE8]
	assign timerLevels = {st.prio[3], st.prio[4],
		st.prio[5][15:8]}; // [RULE9] [RULE10] [RULE11]
	assign serial0Level = st.prio[5][7:4]; // [RULE11]

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	reset_clears_a: assert property (disable iff (1'b0) // [RULE4]
		!rst_n |=> st.prio == '0)
		else $error("priority words not cleared by reset");

	manual_clears_a: assert property ( // [RULE4]
		!manualRst_n |=> st.prio == '0)
		else $error("priority words not cleared by manual reset");

	write_stores_a: assert property ( // [RULE1]
		rb.wrEn && manualRst_n && rb.idx < 4'(NUM_REGS) |=>
		st.prio[$past(rb.idx[2:0])] ==
		($past(rb.wdata) & REG_WMASK[$past(rb.idx[2:0])]))
		else $error("write not stored");

	reserved_zero_a: assert property ( // [RULE13]
		##1 st.prio[7][7:0] == 8'h00)
		else $error("reserved bits not zero");

	standby_hold_a: assert property ( // [RULE5]
		$changed(standby) && !rb.wrEn && manualRst_n |=>
		$stable(st.prio))
		else $error("standby changed priority words");

	shared_field_a: assert property ( // [RULE14]
		srcLevel[S_WDOG] == srcLevel[S_BUS] &&
		srcLevel[S_CONV1] == srcLevel[S_CONV1 - 1])
		else $error("shared field gives different levels");

	mask_gate_a: assert property ( // [RULE19]
		manualRst_n ##1 irqReq |-> irqLevel > $past(cpuMaskLevel))
		else $error("request forwarded at or below mask");

	forward_a: assert property ( // [RULE19]
		manualRst_n && reqs[S_PORT] && srcLevel[S_PORT] > cpuMaskLevel
		|=> irqReq && irqLevel >= $past(srcLevel[S_PORT]))
		else $error("request above mask not forwarded");

	top_level_a: assert property ( // [RULE3]
		manualRst_n && reqs[S_PORT] && srcLevel[S_PORT] == 4'hF &&
		cpuMaskLevel == 4'hE |=> irqReq ##0 irqLevel == 4'hF)
		else $error("level fifteen not above fourteen");

	tie_order_a: assert property ( // [RULE18]
		manualRst_n && reqs == 12'h003 &&
		srcLevel[S_ERR] > cpuMaskLevel |=> irqVector == 8'h84)
		else $error("error request lost tie to receive");

	vec_addr_a: assert property ( // [RULE15]
		irqReq |-> irqVecAddr == 10'(irqVector) * 10'h004)
		else $error("vector address not four times vector");

	read_stall_a: assert property (
		hsel && htrans[1] && !hwrite && hready |=>
		!hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

	forward_c: cover property (manualRst_n ##1 irqReq);
	tie_c: cover property (reqs[S_WDOG] && reqs[S_BUS] ##1 irqReq);
	standby_c: cover property ($fell(standby) && st.prio != '0);
	write_c: cover property (rb.wrEn ##1 hsel && htrans[1] && !hwrite);
endmodule

// *** bench/cpu_core_model.sv ***
// CPU core stand-in: holds the interrupt mask level seen by the selector.
// Assumes the bench loads a new mask through maskLoad on mclk.
`timescale 1ns/10ps
module cpu_core_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Mask control from the bench
	input wire logic maskLoad,
	input wire logic [3:0] maskIn,
	// To the controller
	output logic [3:0] cpuMaskLevel
);
	////////////////////////////////////////////////////////////////////////
	// Registered like a status register, so a new mask lands one edge late
	always_ff @(posedge mclk) begin
		if (!rst_n)
			cpuMaskLevel <= 4'h0;
		else if (maskLoad)
			cpuMaskLevel <= maskIn;
	end
endmodule

// *** bench/interrupt_priority_map_tb_top.sv ***
// Bench for the priority map: register bank, level outputs, selection.
// Assumes one AHB-Lite master here and the CPU stand-in beside the design.
`timescale 1ns/10ps
module interrupt_priority_map_tb_top
	import irq_prio_pkg::*;
;
	logic mclk, rst_n, manualRst_n, standby, hsel, hwrite, maskLoad;
	logic hreadyout, hresp, irqReq;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, extPinLevels, rd;
	logic [3:0] irqLevel, cpuMaskLevel, maskIn, serial0Level;
	logic [7:0] irqVector;
	logic [9:0] irqVecAddr;
	logic [15:0] dmaLevels;
	logic [39:0] timerLevels;
	logic [11:0] reqs;
	logic [15:0] w [8];
	int err_total, samples_checked;
	// Rows: requests, mask, then expected irqReq, level, vector
	localparam logic [28:0] ROWS [19] = '{
		{12'h001, 4'h0, 1'b1, 4'h7, 8'h84}, {12'h00E, 4'h0, 1'b1, 4'h7, 8'h85},
		{12'h00C, 4'h0, 1'b1, 4'h7, 8'h86}, {12'h008, 4'h0, 1'b1, 4'h7, 8'h87},
		{12'h010, 4'h0, 1'b1, 4'h9, 8'h88}, {12'h020, 4'h0, 1'b1, 4'h9, 8'h89},
		{12'h030, 4'h0, 1'b1, 4'h9, 8'h88}, {12'h040, 4'h2, 1'b1, 4'h3, 8'h8C},
		{12'h040, 4'h3, 1'b0, 4'h0, 8'h00}, {12'h080, 4'h0, 1'b1, 4'h5, 8'h90},
		{12'h100, 4'h0, 1'b1, 4'h7, 8'h94}, {12'h600, 4'h0, 1'b1, 4'hB, 8'h98},
		{12'h400, 4'h0, 1'b1, 4'hB, 8'h99}, {12'h800, 4'h0, 1'b1, 4'h7, 8'h9C},
		{12'h101, 4'h0, 1'b1, 4'h7, 8'h84}, {12'h900, 4'h6, 1'b1, 4'h7, 8'h94},
		{12'hFFF, 4'hA, 1'b1, 4'hB, 8'h98}, {12'hFFF, 4'hB, 1'b0, 4'h0, 8'h00},
		{12'h003, 4'h0, 1'b1, 4'h7, 8'h84}};

	////////////////////////////////////////////////////////////////////////
	// Design and CPU stand-in; hready is the slave's own hreadyout
	interrupt_priority_map #(.TwoConverterSources(1'b1))
		i_interrupt_priority_map (
		.mclk(mclk), .rst_n(rst_n), .manualRst_n(manualRst_n),
		.standby(standby), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.serial1ErrorReq(reqs[0]), .serial1RxReq(reqs[1]),
		.serial1TxReq(reqs[2]), .serial1TxEndReq(reqs[3]),
		.converter0EndReq(reqs[4]), .converter1EndReq(reqs[5]),
		.xferSwRequest(reqs[6]), .cmpTimer0MatchReq(reqs[7]),
		.cmpTimer1MatchReq(reqs[8]), .wdogIntervalReq(reqs[9]),
		.busRefreshMatchReq(reqs[10]), .portOutputReq(reqs[11]),
		.cpuMaskLevel(cpuMaskLevel), .irqReq(irqReq), .irqLevel(irqLevel),
		.irqVector(irqVector), .irqVecAddr(irqVecAddr),
		.extPinLevels(extPinLevels), .dmaLevels(dmaLevels),
		.timerLevels(timerLevels), .serial0Level(serial0Level));
	cpu_core_model i_cpu_core_model (.mclk(mclk), .rst_n(rst_n),
		.maskLoad(maskLoad), .maskIn(maskIn), .cpuMaskLevel(cpuMaskLevel));

	////////////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////
	// Compare, verdict and bus tasks
	task automatic check(input logic [39:0] seen, input logic [39:0] want);
		samples_checked++;
		if (seen !== want) begin
			err_total++;
			$display("unexpected at %0t: seen %h want %h", $time, seen, want);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Bounded wait so a stuck hreadyout ends the run instead of hanging
	task automatic waitReady();
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			err_total++;
			complete_run();
		end
	endtask

	// One single word transfer; entered just after a rising edge
	task automatic ahb(input logic wr, input logic [31:0] a,
		input logic [15:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		waitReady();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0000, d};
		waitReady();
		rd = hrdata;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst_n = 1'b0;
		manualRst_n = 1'b1;
		standby = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0;
		reqs = 12'h000;
		maskLoad = 1'b0;
		maskIn = 4'h0;
		err_total = 0;
		samples_checked = 0;
		w = '{16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0, 16'h2468, 16'hACE7,
			16'h9357, 16'hB7FF};
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		// Reset value, write, read back; low byte of the last word reserved
		for (int i = 0; i < 8; i++) begin
			ahb(1'b0, MAP_OFS[i], 16'h0000);
			check(rd, 40'h0);
			ahb(1'b1, MAP_OFS[i], w[i]);
			ahb(1'b0, MAP_OFS[i], w[i]);
			check(rd, (i == 7) ? w[i] & 16'hFF00 : w[i]);
		end
		check(extPinLevels, {w[0], w[1]});
		check(dmaLevels, w[2]);
		check(timerLevels, {w[3], w[4], w[5][15:8]});
		check(serial0Level, w[5][7:4]);
		// Unmapped place takes no write and reads zero
		ahb(1'b1, 32'h40, 16'hFFFF);
		ahb(1'b0, 32'h40, 16'h0000);
		check(rd, 40'h0);
		// Selection table; mask passes through the CPU stand-in
		maskLoad <= 1'b1;
		for (int i = 0; i < 19; i++) begin
			reqs <= ROWS[i][28:17];
			maskIn <= ROWS[i][16:13];
			repeat (3) @(posedge mclk);
			check(irqReq, ROWS[i][12]);
			check(irqLevel, ROWS[i][11:8]);
			check(irqVector, ROWS[i][7:0]);
			check(irqVecAddr, {ROWS[i][7:0], 2'b00});
		end
		// Status and pending views while the last row still stands
		ahb(1'b0, MAP_OFS[8], 16'h0000);
		check(rd, 40'h8784);
		ahb(1'b0, MAP_OFS[9], 16'h0000);
		check(rd, 40'h0003);
		check(hresp, 40'h0);
		// Standby keeps contents
		standby <= 1'b1;
		repeat (4) @(posedge mclk);
		ahb(1'b0, MAP_OFS[0], 16'h0000);
		check(rd, w[0]);
		standby <= 1'b0;
		// Manual reset clears words; zero levels never beat mask 0
		maskIn <= 4'h0;
		manualRst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		manualRst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		check(irqReq, 40'h0);
		ahb(1'b0, MAP_OFS[7], 16'h0000);
		check(rd, 40'h0);
		ahb(1'b0, MAP_OFS[5], 16'h0000);
		check(rd, 40'h0);
		complete_run();
	end
endmodule
